/* File: tfl_host_model.sv */
// Serial bus host that programs and polls the limit block
`timescale 1ns/100ps
`include "tfl_map.svh"
module tfl_host_model (
    input  wire logic mclk,
    input  wire logic sdaLine,
    output logic      sclDrv,
    output logic      sdaDrv
);
    // Both lines released at power-up
    initial begin
        sclDrv = 1'b1;
        sdaDrv = 1'b1;
    end
    // All bus moves are made on falling mclk edges
    task automatic tk(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // One bit: data set while clock low, sampled at end of high
    task automatic bitx(input logic b, output logic r);
        sdaDrv = b;
        tk(6);
        sclDrv = 1'b1;
        tk(6);
        r = sdaLine;
        sclDrv = 1'b0;
        tk(2);
    endtask
    // Start or repeated start
    task automatic start();
        sdaDrv = 1'b1;
        tk(6);
        sclDrv = 1'b1;
        tk(6);
        sdaDrv = 1'b0;
        tk(6);
        sclDrv = 1'b0;
        tk(2);
    endtask
    // Stop, leaving both lines released
    task automatic stop();
        sdaDrv = 1'b0;
        tk(6);
        sclDrv = 1'b1;
        tk(6);
        sdaDrv = 1'b1;
        tk(6);
    endtask
    // Eight bits then the acknowledge slot
    task automatic xbyte(input logic [7:0] d, input logic ai, output logic [7:0] r,
                         output logic ao);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r[i]);
        end
        bitx(ai, ao);
    endtask
    // Pointer then one data byte
    task automatic wr_reg(input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic       a0;
        logic       a1;
        logic       a2;
        start();
        xbyte({`TFL_SMB_ADDR, 1'b0}, 1'b1, r, a0);
        xbyte(p, 1'b1, r, a1);
        xbyte(d, 1'b1, r, a2);
        stop();
        ok = !(a0 | a1 | a2);
    endtask
    task automatic rd_reg(input logic [7:0] p, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic       a0;
        logic       a1;
        logic       a2;
        start();
        xbyte({`TFL_SMB_ADDR, 1'b0}, 1'b1, r, a0);
        xbyte(p, 1'b1, r, a1);
        start();
        xbyte({`TFL_SMB_ADDR, 1'b1}, 1'b1, r, a2);
        xbyte(8'hFF, 1'b1, d, r[0]);
        stop();
        ok = !(a0 | a1 | a2);
    endtask
endmodule // tfl_host_model

/* File: tfl_limit_compare.sv */
// Limit comparison, status and alert logic of the temperature and fan monitor
`timescale 1ns/100ps
`include "tfl_map.svh"
module tfl_limit_compare (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              sclIn,
    input  wire logic              sdaIn,
    output logic                   sdaOut,
    output logic                   sdaOe,
    output logic                   convReq,
    output tfl_pkg::tfl_chan_t     convChannel,
    input  wire logic              convDone,
    input  wire logic [15:0]       convData,
    input  wire logic              tachValid,
    input  wire logic [15:0]       tachCount,
    input  wire logic              fanManual,
    output logic                   alertOut,
    output logic                   alertOe
);
    import tfl_pkg::*;

    tfl_reg_if regBus ();

    tfl_rr_state_t rrState,     next_rrState;
    tfl_chan_t     channel,     next_channel;
    logic          req,         next_req;
    logic [7:0]    locHigh,     next_locHigh;
    logic [7:0]    locLow,      next_locLow;
    logic [7:0]    locOvt,      next_locOvt;
    logic [7:0]    remHighUp,   next_remHighUp;
    logic [7:0]    remHighLo,   next_remHighLo;
    logic [7:0]    remLowUp,    next_remLowUp;
    logic [7:0]    remLowLo,    next_remLowLo;
    logic [7:0]    remOvt,      next_remOvt;
    logic [7:0]    fanLimLo,    next_fanLimLo;
    logic [7:0]    fanLimHi,    next_fanLimHi;
    logic [7:0]    mask1,       next_mask1;
    logic [7:0]    mask2,       next_mask2;
    logic [7:0]    cond1,       next_cond1;
    logic [7:0]    cond2,       next_cond2;
    logic [7:0]    sticky1,     next_sticky1;
    logic          next_alert;
    logic          status1Read;
    logic [7:0]    readMux;

    // Strict greater-than test for high limits
    function automatic logic overHigh(input logic [15:0] value, input logic [15:0] limit);
        return value > limit;
    endfunction

    // At-or-below test for low limits
    function automatic logic atOrBelowLow(input logic [15:0] value,
                                          input logic [15:0] limit);
        return value <= limit;
    endfunction

    // Serial slave front end
    tfl_smb_slave u_smb (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .sclIn  (sclIn),
        .sdaIn  (sdaIn),
        .sdaOut (sdaOut),
        .sdaOe  (sdaOe),
        .bus    (regBus)
    );

    always_comb begin
        next_rrState = rrState;
        next_channel = channel;
        next_req     = req;
        unique case (rrState)
            TFL_RR_REQ: begin
                next_req     = 1'b1;
                next_rrState = TFL_RR_WAIT;
            end
            TFL_RR_WAIT: begin
                if (convDone) begin
                    next_req     = 1'b0;
                    next_rrState = TFL_RR_REQ;
                    next_channel = (channel == TFL_CH_LOCAL) ? TFL_CH_REMOTE : TFL_CH_LOCAL;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rrState <= TFL_RR_REQ;
            channel <= TFL_CH_LOCAL;
            req     <= 1'b0;
        end else begin
            rrState <= next_rrState;
            channel <= next_channel;
            req     <= next_req;
        end
    end

    assign convReq     = req;
    assign convChannel = channel;

    // Register writes from the serial port
    always_comb begin
        next_locHigh   = locHigh;
        next_locLow    = locLow;
        next_locOvt    = locOvt;
        next_remHighUp = remHighUp;
        next_remHighLo = remHighLo;
        next_remLowUp  = remLowUp;
        next_remLowLo  = remLowLo;
        next_remOvt    = remOvt;
        next_fanLimLo  = fanLimLo;
        next_fanLimHi  = fanLimHi;
        next_mask1     = mask1;
        next_mask2     = mask2;
        if (regBus.wrStb) begin
            case (regBus.addr)
                `TFL_OFS_LOC_HIGH:    next_locHigh   = regBus.wrData;
                `TFL_OFS_LOC_LOW:     next_locLow    = regBus.wrData;
                `TFL_OFS_LOC_OVT:     next_locOvt    = regBus.wrData;
                `TFL_OFS_REM_HIGH_UP: next_remHighUp = regBus.wrData;
                `TFL_OFS_REM_HIGH_LO: next_remHighLo = regBus.wrData;
                `TFL_OFS_REM_LOW_UP:  next_remLowUp  = regBus.wrData;
                `TFL_OFS_REM_LOW_LO:  next_remLowLo  = regBus.wrData;
                `TFL_OFS_REM_OVT:     next_remOvt    = regBus.wrData;
                `TFL_OFS_FAN_LIM_LO:  next_fanLimLo  = regBus.wrData;
                `TFL_OFS_FAN_LIM_HI:  next_fanLimHi  = regBus.wrData;
                `TFL_OFS_MASK1:       next_mask1     = regBus.wrData;
                `TFL_OFS_MASK2:       next_mask2     = regBus.wrData;
                default:              next_mask2     = mask2;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            locHigh   <= `TFL_RST_HIGH;
            locLow    <= `TFL_RST_LOW;
            locOvt    <= `TFL_RST_OVT;
            remHighUp <= `TFL_RST_HIGH;
            remHighLo <= `TFL_RST_HIGH;
            remLowUp  <= `TFL_RST_LOW;
            remLowLo  <= `TFL_RST_LOW;
            remOvt    <= `TFL_RST_OVT;
            fanLimLo  <= `TFL_RST_FAN;
            fanLimHi  <= `TFL_RST_FAN;
            mask1     <= `TFL_RST_MASK;
            mask2     <= `TFL_RST_MASK;
        end else begin
            locHigh   <= next_locHigh;
            locLow    <= next_locLow;
            locOvt    <= next_locOvt;
            remHighUp <= next_remHighUp;
            remHighLo <= next_remHighLo;
            remLowUp  <= next_remLowUp;
            remLowLo  <= next_remLowLo;
            remOvt    <= next_remOvt;
            fanLimLo  <= next_fanLimLo;
            fanLimHi  <= next_fanLimHi;
            mask1     <= next_mask1;
            mask2     <= next_mask2;
        end
    end

    // Live conditions, refreshed by each finished comparison
    always_comb begin
        next_cond1 = cond1;
        next_cond2 = cond2;
        if (convDone && rrState == TFL_RR_WAIT) begin
            if (channel == TFL_CH_LOCAL) begin
                next_cond1[`TFL_ST1_LOCAL] =
                    overHigh({8'h00, convData[15:8]}, {8'h00, locHigh})
                    | atOrBelowLow({8'h00, convData[15:8]}, {8'h00, locLow});
                next_cond2[`TFL_ST2_LOC_OVT] =
                    overHigh({8'h00, convData[15:8]}, {8'h00, locOvt});
            end else begin
                // remote window on joined limit bytes
                next_cond1[`TFL_ST1_REM_HIGH] = overHigh(convData, {remHighUp, remHighLo});
                next_cond1[`TFL_ST1_REM_LOW]  = atOrBelowLow(convData, {remLowUp, remLowLo});
                next_cond1[`TFL_ST1_REM_OVT]  =
                    overHigh({8'h00, convData[15:8]}, {8'h00, remOvt});
            end
        end
        // tach check on its own strobe, manual mode only
        if (tachValid) begin
            next_cond1[`TFL_ST1_FAN] = fanManual & ~(tachCount < {fanLimHi, fanLimLo});
        end else if (!fanManual) begin
            next_cond1[`TFL_ST1_FAN] = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cond1 <= 8'h00;
            cond2 <= 8'h00;
        end else begin
            cond1 <= next_cond1;
            cond2 <= next_cond2;
        end
    end

    assign status1Read = regBus.rdStb && regBus.addr == `TFL_OFS_STATUS1;

    // sticky bits, a set always wins over the read clear
    for (genvar i = 0; i < 8; i++) begin : g_sticky
        always_comb begin
            next_sticky1[i] = next_cond1[i] | (sticky1[i] & ~(status1Read & ~cond1[i]));
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sticky1 <= 8'h00;
        end else begin
            sticky1 <= next_sticky1;
        end
    end

    // unmasked status drives the shared alert line low
    always_comb begin
        next_alert = |(next_sticky1 & ~mask1 & `TFL_ST1_ALERTABLE)
                     | |(next_cond2 & ~mask2 & `TFL_ST2_ALERTABLE);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            alertOut <= 1'b0;
            alertOe  <= 1'b0;
        end else begin
            alertOut <= 1'b0;
            alertOe  <= next_alert;
        end
    end

    // read-back mux, unmapped offsets read zero
    always_comb begin
        case (regBus.addr)
            `TFL_OFS_STATUS1:     readMux = sticky1;
            `TFL_OFS_STATUS2:     readMux = cond2;
            `TFL_OFS_LOC_HIGH:    readMux = locHigh;
            `TFL_OFS_LOC_LOW:     readMux = locLow;
            `TFL_OFS_LOC_OVT:     readMux = locOvt;
            `TFL_OFS_REM_HIGH_UP: readMux = remHighUp;
            `TFL_OFS_REM_HIGH_LO: readMux = remHighLo;
            `TFL_OFS_REM_LOW_UP:  readMux = remLowUp;
            `TFL_OFS_REM_LOW_LO:  readMux = remLowLo;
            `TFL_OFS_REM_OVT:     readMux = remOvt;
            `TFL_OFS_FAN_LIM_LO:  readMux = fanLimLo;
            `TFL_OFS_FAN_LIM_HI:  readMux = fanLimHi;
            `TFL_OFS_MASK1:       readMux = mask1;
            `TFL_OFS_MASK2:       readMux = mask2;
            default:              readMux = 8'h00;
        endcase
    end

    assign regBus.rdData = readMux;
endmodule // tfl_limit_compare

/* File: tfl_limit_compare_sva.sv */
// Port checks for the limit comparison block
`timescale 1ns/100ps
module tfl_limit_compare_sva (
    input wire logic          mclk,
    input wire logic          rst_b,
    input wire logic          sclIn,
    input wire logic          sdaOut,
    input wire logic          sdaOe,
    input wire logic          convReq,
    input tfl_pkg::tfl_chan_t convChannel,
    input wire logic          convDone,
    input wire logic          tachValid,
    input wire logic          alertOut,
    input wire logic          alertOe
);
    import tfl_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    a_req_drops: assert property (convReq && convDone |=> !convReq)
        else $error("request stayed high after result");
    a_req_rearm: assert property (convReq && convDone |=> ##1 convReq)
        else $error("request not raised again");
    a_chan_toggle: assert property (convReq && convDone |=> convChannel != $past(convChannel))
        else $error("channel did not alternate");
    a_req_holds: assert property (convReq && !convDone |=> convReq && $stable(convChannel))
        else $error("pending request changed");
    a_start_local: assert property ($rose(rst_b) |-> !convReq && convChannel == TFL_CH_LOCAL)
        else $error("sequence not idle on local");
    a_tach_apart: assert property (tachValid && !(convReq && convDone) |=> $stable(convChannel))
        else $error("tach moved the sequence");
    a_sda_moves: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("data pin moved while clock high");
    a_sda_stands: assert property ($rose(sdaOe) |=> sdaOe [*3])
        else $error("data pin drive too short");
    a_pins_od: assert property (sdaOut == 1'b0 && alertOut == 1'b0)
        else $error("open drain pin driven high");
    cover property (convReq && convDone && convChannel == TFL_CH_REMOTE);
    cover property ($rose(alertOe));
    cover property ($fell(alertOe));
    cover property ($rose(sdaOe));
endmodule // tfl_limit_compare_sva
bind tfl_limit_compare tfl_limit_compare_sva chk (
    .mclk(mclk), .rst_b(rst_b), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .convReq(convReq), .convChannel(convChannel), .convDone(convDone),
    .tachValid(tachValid), .alertOut(alertOut), .alertOe(alertOe));

/* File: tfl_limit_compare_tb_top.sv */
// Self-checking bench for the limit comparison block
`timescale 1ns/100ps
module tfl_limit_compare_tb_top;
    import tfl_pkg::*;
    logic       mclk, rst_b, sclDrv, sdaDrv, sdaOut, sdaOe, sdaLine, convReq;
    logic       convDone, tachValid, fanManual, alertOut, alertOe, ok;
    tfl_chan_t  convChannel;
    logic [15:0] convData, tachCount;
    logic [7:0] rd, prev1, cur1;
    int         failures, numChecks;
    logic [7:0] ofs [10] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h13, 8'h14, 8'h19, 8'h22, 8'h48, 8'h49};
    logic [7:0] rv [10] = '{8'h55, 8'h00, 8'h55, 8'h00, 8'h55, 8'h00, 8'h60, 8'h60, 8'hFF, 8'hFF};
    logic [7:0] wa [4] = '{8'h05, 8'h06, 8'h48, 8'h49};
    logic [7:0] wv [4] = '{8'h50, 8'h10, 8'h00, 8'h10};
    logic [7:0] sl [6] = '{8'h50, 8'h51, 8'h10, 8'h11, 8'h61, 8'h30};
    logic [15:0] sr [6] = '{16'h5555, 16'h5556, 16'h0000, 16'h0001, 16'h6100, 16'h1234};
    logic [15:0] sc [6] = '{16'h0FFF, 16'h1000, 16'hFFFF, 16'h0FFF, 16'hFFFF, 16'h2000};
    logic       sm [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    // Wired data line with pull-up
    assign sdaLine = sdaOe ? (sdaOut & sdaDrv) : sdaDrv;
    tfl_host_model host (.mclk(mclk), .sdaLine(sdaLine), .sclDrv(sclDrv), .sdaDrv(sdaDrv));
    tfl_limit_compare uut (
        .mclk(mclk), .rst_b(rst_b), .sclIn(sclDrv), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .convReq(convReq), .convChannel(convChannel), .convDone(convDone),
        .convData(convData), .tachValid(tachValid), .tachCount(tachCount),
        .fanManual(fanManual), .alertOut(alertOut), .alertOe(alertOe));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        numChecks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] p, input logic [7:0] exp);
        host.rd_reg(p, rd, ok);
        chk({7'h00, ok}, 8'h01, "no ack");
        chk(rd, exp, "register value");
    endtask
    // Converter side: answer a pending request on the expected channel
    task automatic conv(input tfl_chan_t ch, input logic [15:0] d);
        int n;
        n = 0;
        while (convReq !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        chk({7'h00, convReq}, 8'h01, "no request");
        chk({7'h00, convChannel}, {7'h00, ch}, "channel");
        convData = d;
        convDone = 1'b1;
        @(negedge mclk);
        convDone = 1'b0;
        convData = ~d;
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #500_000;
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim();
    end
    initial begin
        {rst_b, convDone, tachValid, fanManual, convData, tachCount} = '0;
        {failures, numChecks, prev1} = '0;
        repeat (6) @(negedge mclk);
        rst_b = 1'b1;
        for (int i = 0; i < 10; i++) begin
            rdchk(ofs[i], rv[i]);
        end
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            host.wr_reg(wa[i], wv[i], ok);
            rdchk(wa[i], wv[i]);
        end
        $display("test limit writes done");
        // Local, remote and fan results against limits, status polled after each
        for (int i = 0; i < 6; i++) begin
            fanManual = sm[i];
            tachCount = sc[i];
            tachValid = 1'b1;
            @(negedge mclk);
            tachValid = 1'b0;
            conv(TFL_CH_LOCAL, {sl[i], 8'h00});
            conv(TFL_CH_REMOTE, sr[i]);
            cur1 = {1'b0, sl[i] > 8'h50 || sl[i] <= 8'h10, 1'b0, sr[i] > 16'h5555,
                    sr[i] <= 16'h0000, 1'b0, sr[i][15:8] > 8'h60, sm[i] && sc[i] >= 16'h1000};
            rdchk(8'h02, prev1 | cur1);
            rdchk(8'h1A, {3'h0, sl[i] > 8'h60, 4'h0});
            chk({7'h00, alertOe}, {7'h00, (cur1 != 8'h00) || sl[i] > 8'h60}, "alert");
            prev1 = cur1;
        end
        $display("test limit compare done");
        // Masked sources still set status but keep the alert line released
        host.wr_reg(8'h16, 8'h5B, ok);
        rdchk(8'h16, 8'h5B);
        conv(TFL_CH_LOCAL, 16'h5100);
        conv(TFL_CH_REMOTE, 16'h0000);
        chk({7'h00, alertOe}, 8'h00, "masked alert");
        rdchk(8'h02, 8'h48);
        $display("test alert mask done");
        end_sim();
    end
endmodule // tfl_limit_compare_tb_top

/* File: tfl_map.svh */
// Register offsets, reset values, field positions and bus constants
`ifndef TFL_MAP_SVH
`define TFL_MAP_SVH

// Register offsets
`define TFL_OFS_STATUS1        8'h02
`define TFL_OFS_LOC_HIGH       8'h05
`define TFL_OFS_LOC_LOW        8'h06
`define TFL_OFS_REM_HIGH_UP    8'h07
`define TFL_OFS_REM_LOW_UP     8'h08
`define TFL_OFS_REM_HIGH_LO    8'h13
`define TFL_OFS_REM_LOW_LO     8'h14
`define TFL_OFS_MASK1          8'h16
`define TFL_OFS_REM_OVT        8'h19
`define TFL_OFS_STATUS2        8'h1A
`define TFL_OFS_MASK2          8'h1B
`define TFL_OFS_LOC_OVT        8'h22
`define TFL_OFS_FAN_LIM_LO     8'h48
`define TFL_OFS_FAN_LIM_HI     8'h49

// Reset values
`define TFL_RST_HIGH           8'h55
`define TFL_RST_LOW            8'h00
`define TFL_RST_OVT            8'h60
`define TFL_RST_FAN            8'hFF
`define TFL_RST_MASK           8'h00

// Status register 1 bit positions
`define TFL_ST1_LOCAL          6
`define TFL_ST1_REM_HIGH       4
`define TFL_ST1_REM_LOW        3
`define TFL_ST1_REM_OVT        1
`define TFL_ST1_FAN            0
// Status register 2 bit positions
`define TFL_ST2_LOC_OVT        4

// Status 1 and status 2 bits that may drive the alert line
`define TFL_ST1_ALERTABLE      8'h5B
`define TFL_ST2_ALERTABLE      8'h10

// Serial port slave address, arbitrary value
`define TFL_SMB_ADDR           7'h2A

`endif

/* File: tfl_pkg.sv */
// Types shared by the limit comparison block
package tfl_pkg;
    typedef enum logic {TFL_CH_LOCAL, TFL_CH_REMOTE} tfl_chan_t;
    typedef enum logic {TFL_RR_REQ, TFL_RR_WAIT} tfl_rr_state_t;
    typedef enum logic [3:0] {
        TFL_SMB_IDLE, TFL_SMB_ADDR, TFL_SMB_ADDR_ACK, TFL_SMB_PTR, TFL_SMB_PTR_ACK,
        TFL_SMB_WDATA, TFL_SMB_WDATA_ACK, TFL_SMB_RDATA, TFL_SMB_RDATA_ACK
    } tfl_smb_state_t;
endpackage

/* File: tfl_reg_if.sv */
// Register access carrier between serial slave and register file
`timescale 1ns/100ps
interface tfl_reg_if;
    logic       wrStb;
    logic       rdStb;
    logic [7:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    modport slave (output wrStb, output rdStb, output addr, output wrData, input rdData);
    modport regs  (input wrStb, input rdStb, input addr, input wrData, output rdData);
endinterface

/* File: tfl_smb_slave.sv */
// Serial bus slave giving byte access to the register file
`timescale 1ns/100ps
`include "tfl_map.svh"
module tfl_smb_slave (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic sclIn,
    input  wire logic sdaIn,
    output logic      sdaOut,
    output logic      sdaOe,
    tfl_reg_if.slave  bus
);
    import tfl_pkg::*;

    tfl_smb_state_t state,    next_state;
    logic [2:0]     bitCnt,   next_bitCnt;
    logic           full,     next_full;
    logic [7:0]     shiftReg, next_shiftReg;
    logic [7:0]     pointer,  next_pointer;
    logic           drive,    next_drive;
    logic           wrStb,    next_wrStb;
    logic           rdStb,    next_rdStb;
    logic           sclPrev;
    logic           sdaPrev;
    logic           startSeen;
    logic           stopSeen;
    logic           sclRise;
    logic           sclFall;

    // Bus conditions from the previous samples
    assign startSeen = sclIn & sclPrev & sdaPrev & ~sdaIn;
    assign stopSeen  = sclIn & sclPrev & ~sdaPrev & sdaIn;
    assign sclRise   = sclIn & ~sclPrev;
    assign sclFall   = ~sclIn & sclPrev;

    assign bus.wrStb  = wrStb;
    assign bus.rdStb  = rdStb;
    assign bus.addr   = pointer;
    assign bus.wrData = shiftReg;

    // Byte framing, acknowledge and pointer handling
    always_comb begin
        next_state    = state;
        next_bitCnt   = bitCnt;
        next_full     = full;
        next_shiftReg = shiftReg;
        next_pointer  = pointer;
        next_drive    = drive;
        next_wrStb    = 1'b0;
        next_rdStb    = 1'b0;
        if (startSeen) begin
            next_state  = TFL_SMB_ADDR;
            next_bitCnt = 3'h0;
            next_full   = 1'b0;
            next_drive  = 1'b0;
        end else if (stopSeen) begin
            next_state = TFL_SMB_IDLE;
            next_drive = 1'b0;
        end else begin
            unique case (state)
                TFL_SMB_IDLE: begin
                    next_drive = 1'b0;
                end
                TFL_SMB_ADDR, TFL_SMB_PTR, TFL_SMB_WDATA: begin
                    if (sclRise) begin
                        next_shiftReg = {shiftReg[6:0], sdaIn};
                        next_bitCnt   = bitCnt + 3'h1;
                        next_full     = (bitCnt == 3'h7);
                    end
                    // Byte complete only at the clock fall after its eighth bit
                    if (sclFall && full) begin
                        next_full = 1'b0;
                        if (state == TFL_SMB_ADDR) begin
                            // Only our own address is acknowledged
                            next_state = (shiftReg[7:1] == `TFL_SMB_ADDR)
                                         ? TFL_SMB_ADDR_ACK : TFL_SMB_IDLE;
                            next_drive = (shiftReg[7:1] == `TFL_SMB_ADDR);
                        end else if (state == TFL_SMB_PTR) begin
                            next_state   = TFL_SMB_PTR_ACK;
                            next_pointer = shiftReg;
                            next_drive   = 1'b1;
                        end else begin
                            next_state = TFL_SMB_WDATA_ACK;
                            next_wrStb = 1'b1;
                            next_drive = 1'b1;
                        end
                    end
                end
                TFL_SMB_ADDR_ACK: begin
                    if (sclFall) begin
                        if (shiftReg[0]) begin
                            // Read: fetch byte at pointer and drive its first bit
                            next_state    = TFL_SMB_RDATA;
                            next_shiftReg = bus.rdData;
                            next_rdStb    = 1'b1;
                            next_drive    = ~bus.rdData[7];
                        end else begin
                            next_state = TFL_SMB_PTR;
                            next_drive = 1'b0;
                        end
                    end
                end
                TFL_SMB_PTR_ACK: begin
                    if (sclFall) begin
                        next_state = TFL_SMB_WDATA;
                        next_drive = 1'b0;
                    end
                end
                TFL_SMB_WDATA_ACK: begin
                    if (sclFall) begin
                        next_state   = TFL_SMB_WDATA;
                        next_pointer = pointer + 8'h01;
                        next_drive   = 1'b0;
                    end
                end
                TFL_SMB_RDATA: begin
                    if (sclFall) begin
                        next_bitCnt   = bitCnt + 3'h1;
                        next_shiftReg = {shiftReg[6:0], 1'b0};
                        next_drive    = (bitCnt == 3'h7) ? 1'b0 : ~shiftReg[6];
                        if (bitCnt == 3'h7) begin
                            next_state   = TFL_SMB_RDATA_ACK;
                            next_pointer = pointer + 8'h01;
                        end
                    end
                end
                TFL_SMB_RDATA_ACK: begin
                    // Master acknowledge continues, no acknowledge ends the read
                    if (sclRise && sdaIn) begin
                        next_state = TFL_SMB_IDLE;
                    end else if (sclFall) begin
                        next_state    = TFL_SMB_RDATA;
                        next_shiftReg = bus.rdData;
                        next_rdStb    = 1'b1;
                        next_drive    = ~bus.rdData[7];
                    end
                end
                default: begin
                    next_state = TFL_SMB_IDLE;
                    next_drive = 1'b0;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state    <= TFL_SMB_IDLE;
            bitCnt   <= 3'h0;
            full     <= 1'b0;
            shiftReg <= 8'h00;
            pointer  <= 8'h00;
            drive    <= 1'b0;
            wrStb    <= 1'b0;
            rdStb    <= 1'b0;
            sclPrev  <= 1'b1;
            sdaPrev  <= 1'b1;
            sdaOut   <= 1'b0;
            sdaOe    <= 1'b0;
        end else begin
            state    <= next_state;
            bitCnt   <= next_bitCnt;
            full     <= next_full;
            shiftReg <= next_shiftReg;
            pointer  <= next_pointer;
            drive    <= next_drive;
            wrStb    <= next_wrStb;
            rdStb    <= next_rdStb;
            sclPrev  <= sclIn;
            sdaPrev  <= sdaIn;
            sdaOut   <= 1'b0;
            sdaOe    <= next_drive;
        end
    end
endmodule // tfl_smb_slave
